// ==== shared/sbg_pkg.sv ====
// Package for the serial baud rate generator: register map, fields, state
`default_nettype none
package sbg_pkg;
    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] OFF_DIVISOR_LOW  = 8'h04;
    localparam logic [7:0] OFF_DIVISOR_HIGH = 8'h08;
    localparam logic [7:0] OFF_MODE         = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS   = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h14;
    localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h18;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_ABD_OVF  = 7;
    localparam int BIT_RX_IDLE  = 6;
    localparam int BIT_CK_POL   = 4;
    localparam int BIT_WIDE     = 3;
    localparam int BIT_WAKE     = 1;
    localparam int BIT_ABD_EN   = 0;
    localparam int BIT_SYNC     = 0;
    localparam int BIT_HSPEED   = 1;
    localparam int IRQ_WAKE     = 0;
    localparam int IRQ_ABD_DONE = 1;
    localparam int IRQ_ABD_OVF  = 2;
    localparam int IRQ_W        = 3;
    // ****************************************************************
    // Reset values, multipliers, responses
    // ****************************************************************
    localparam logic [7:0] RST_BAUD_CONTROL = 8'h40;
    localparam logic [6:0] MULT_64 = 7'h40;
    localparam logic [6:0] MULT_16 = 7'h10;
    localparam logic [6:0] MULT_4  = 7'h04;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        r_ctl;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        abd_ovf;
        logic        rx_idle;
        logic        ck_pol;
        logic        wide;
        logic        wake_en;
        logic        abd_en;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic        sync_mode;
        logic        high_speed;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic        irq;
        logic [5:0]  pre;
        logic [15:0] timer;
        logic        tick;
        logic        rx_prev;
        logic        tx_pin;
        logic        ck_rising;
        logic        rx_ready;
        logic        rx_hold;
    } sbg_state_t;
endpackage
`default_nettype wire

// ==== hw/sbg_baud_gen.sv ====
// Baud rate generator with baud control register behind an AXI4-Lite slave
// Behaviour
// RQ1: Async: overflow flag set when auto-baud timer overflows, else zero.
// RQ2: Async: idle flag one while idle, zero once start bit seen.
// RQ3: Async: polarity select one inverts transmitted data, zero passes it.
// RQ4: Sync: polarity one clocks data on rising edge, zero on falling.
// RQ5: Wide select gives 16-bit divider from both divisors, else 8-bit.
// RQ6: Async wake enable waits for falling edge; edge sets receive-ready flag.
// RQ7: Wake enable clears itself after the wake edge set receive-ready.
// RQ8: Async: auto-baud enable starts detection, clears itself on completion.
// RQ9: Two unimplemented control bits ignore writes and read zero.
// RQ10: Timer runs freely; period is multiplier times divisor value plus one.
// RQ11: Async, normal speed, 8-bit: multiplier 64.
// RQ12: Async, normal speed, 16-bit: multiplier 16.
// RQ13: Sync: multiplier 4 for both divider widths.
// RQ14: High-speed select ignored in sync mode.
// RQ15: Any divisor write clears the timer at once.
// RQ16: Software checks idle flag before changing the system clock.
// RQ17: Async high speed: multiplier 16 for 8-bit, 4 for 16-bit.
`timescale 1ns/1ps
`default_nettype none
module sbg_baud_gen (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        rx_start_i,
    input  wire logic        rx_done_i,
    input  wire logic        rx_line_i,
    input  wire logic        tx_data_i,
    input  wire logic        abd_ovf_i,
    input  wire logic        abd_done_i,
    output logic             baud_tick_o,
    output logic             tx_pin_o,
    output logic             ck_rising_o,
    output logic             rx_ready_o,
    output logic             rx_hold_o,
    output logic             abd_active_o,
    output logic             irq_o
);
    import sbg_pkg::*;

    sbg_state_t s;
    sbg_state_t next_s;
    logic [6:0]  mult;
    logic [15:0] n_val;
    logic [7:0]  ctl_rd;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_go;
    logic        wr_ok;
    logic        div_wr;
    logic        wake_edge;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;

    // ****************************************************************
    // Rate selection
    // ****************************************************************
    always_comb begin
        // The high-speed select only counts in async mode
        if (s.sync_mode) begin
            mult = MULT_4;                                      // [RQ13] [RQ14]
        end else if (!s.high_speed) begin
            mult = s.wide ? MULT_16 : MULT_64;                  // [RQ11] [RQ12]
        end else begin
            mult = s.wide ? MULT_4 : MULT_16;                   // [RQ17]
        end
        n_val = s.wide ? {s.div_hi, s.div_lo} : {8'h00, s.div_lo}; // [RQ5]
    end

    // ****************************************************************
    // Register read view
    // ****************************************************************
    always_comb begin
        ctl_rd = 8'h00;                                         // [RQ9]
        ctl_rd[BIT_ABD_OVF] = s.abd_ovf;
        ctl_rd[BIT_RX_IDLE] = s.rx_idle;
        ctl_rd[BIT_CK_POL]  = s.ck_pol;
        ctl_rd[BIT_WIDE]    = s.wide;
        ctl_rd[BIT_WAKE]    = s.wake_en;
        ctl_rd[BIT_ABD_EN]  = s.abd_en;
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr_i)
            OFF_BAUD_CONTROL: rd_val[7:0] = ctl_rd;
            OFF_DIVISOR_LOW:  rd_val[7:0] = s.div_lo;
            OFF_DIVISOR_HIGH: rd_val[7:0] = s.div_hi;
            OFF_MODE:         rd_val[1:0] = {s.high_speed, s.sync_mode};
            OFF_IRQ_STATUS:   rd_val[IRQ_W-1:0] = s.irq_stat;
            OFF_IRQ_CLEAR:    rd_val = 32'h0000_0000;
            OFF_IRQ_ENABLE:   rd_val[IRQ_W-1:0] = s.irq_en;
            default:          rd_ok = 1'b0;
        endcase
    end

    // A write completes once address and data are both held and no response waits
    assign wr_go  = s.aw_have && s.w_have && !s.bvalid;
    assign wr_ok  = wr_go && s.wstrb0;
    assign div_wr = wr_ok && (s.awaddr == OFF_DIVISOR_LOW || s.awaddr == OFF_DIVISOR_HIGH);
    assign wake_edge = s.wake_en && !s.sync_mode && s.rx_prev && !rx_line_i; // [RQ6]

    always_comb begin
        ev = '0;
        ev[IRQ_WAKE]     = wake_edge;
        ev[IRQ_ABD_DONE] = s.abd_en && !s.sync_mode && abd_done_i;
        ev[IRQ_ABD_OVF]  = s.abd_en && !s.sync_mode && abd_ovf_i;
        clr = '0;
        if (wr_ok && s.awaddr == OFF_IRQ_CLEAR) begin
            clr = s.wdata[IRQ_W-1:0];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        // Write channel: address and data taken in either order
        if (s_axi_awvalid_i && s.awready) begin
            next_s.aw_have = 1'b1;
            next_s.awaddr  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s.wready) begin
            next_s.w_have = 1'b1;
            next_s.wdata  = s_axi_wdata_i[7:0];
            next_s.wstrb0 = s_axi_wstrb_i[0];
        end
        next_s.awready = !next_s.aw_have && !s.bvalid;
        next_s.wready  = !next_s.w_have && !s.bvalid;
        if (s.bvalid && s_axi_bready_i) begin
            next_s.bvalid  = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
        end
        if (wr_go) begin
            next_s.aw_have = 1'b0;
            next_s.w_have  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.awready = 1'b0;
            next_s.wready  = 1'b0;
            next_s.bresp   = RESP_OKAY;
            // Status is read-only; unmapped and unaligned addresses are refused
            if (s.awaddr == OFF_IRQ_STATUS || s.awaddr > OFF_IRQ_ENABLE
                || s.awaddr[1:0] != 2'b00) begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (wr_ok) begin
            unique case (s.awaddr)
                OFF_BAUD_CONTROL: begin
                    next_s.abd_ovf = s.wdata[BIT_ABD_OVF];
                    next_s.ck_pol  = s.wdata[BIT_CK_POL];
                    next_s.wide    = s.wdata[BIT_WIDE];
                    next_s.wake_en = s.wdata[BIT_WAKE];
                    next_s.abd_en  = s.wdata[BIT_ABD_EN];         // [RQ8]
                end
                OFF_DIVISOR_LOW:  next_s.div_lo = s.wdata;
                OFF_DIVISOR_HIGH: next_s.div_hi = s.wdata;
                OFF_MODE: begin
                    next_s.sync_mode  = s.wdata[BIT_SYNC];
                    next_s.high_speed = s.wdata[BIT_HSPEED];
                end
                OFF_IRQ_ENABLE:   next_s.irq_en = s.wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // Read channel
        next_s.arready = !s.rvalid;
        if (s_axi_arvalid_i && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid  = 1'b1;
            next_s.rdata   = rd_val;
            next_s.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
            next_s.r_ctl   = s_axi_araddr_i == OFF_BAUD_CONTROL;
        end else if (s.rvalid && s_axi_rready_i) begin
            next_s.rvalid  = 1'b0;
            next_s.arready = 1'b1;
        end
        // Hardware flags: sets come after the software write so they win
        if (ev[IRQ_ABD_OVF]) begin
            next_s.abd_ovf = 1'b1;                              // [RQ1]
        end
        if (ev[IRQ_ABD_DONE]) begin
            next_s.abd_en = 1'b0;                               // [RQ8]
        end
        if (!s.sync_mode && rx_start_i) begin
            next_s.rx_idle = 1'b0;                              // [RQ2]
        end else if (!s.sync_mode && rx_done_i) begin
            next_s.rx_idle = 1'b1;                              // [RQ2]
        end
        if (wake_edge) begin
            next_s.wake_en = 1'b0;                              // [RQ7]
        end
        next_s.rx_ready = wake_edge;                            // [RQ6]
        next_s.rx_prev  = rx_line_i;
        next_s.irq_stat = (s.irq_stat & ~clr) | ev;
        next_s.irq      = |(next_s.irq_stat & next_s.irq_en);
        // Free-running rate timer
        next_s.tick = 1'b0;
        if (div_wr) begin
            next_s.pre   = 6'h00;                               // [RQ15]
            next_s.timer = 16'h0000;                            // [RQ15]
        end else if ({1'b0, s.pre} >= mult - 7'h01) begin
            next_s.pre = 6'h00;
            if (s.timer >= n_val) begin
                next_s.timer = 16'h0000;                        // [RQ10]
                next_s.tick  = 1'b1;
            end else begin
                next_s.timer = s.timer + 16'h0001;
            end
        end else begin
            next_s.pre = s.pre + 6'h01;
        end
        next_s.tx_pin    = tx_data_i ^ (s.ck_pol && !s.sync_mode); // [RQ3]
        next_s.ck_rising = s.ck_pol && s.sync_mode;             // [RQ4]
        next_s.rx_hold   = next_s.wake_en && !s.sync_mode;      // [RQ6]
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s         <= '0;
            s.rx_idle <= RST_BAUD_CONTROL[BIT_RX_IDLE];
            s.rx_prev <= 1'b1;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready_o = s.awready;
    assign s_axi_wready_o  = s.wready;
    assign s_axi_bvalid_o  = s.bvalid;
    assign s_axi_bresp_o   = s.bresp;
    assign s_axi_arready_o = s.arready;
    assign s_axi_rvalid_o  = s.rvalid;
    assign s_axi_rdata_o   = s.rdata;
    assign s_axi_rresp_o   = s.rresp;
    assign baud_tick_o     = s.tick;
    assign tx_pin_o        = s.tx_pin;
    assign ck_rising_o     = s.ck_rising;
    assign rx_ready_o      = s.rx_ready;
    assign rx_hold_o       = s.rx_hold;
    assign abd_active_o    = s.abd_en;
    assign irq_o           = s.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Cycles since the last tick; any write that may change the rate restarts it
    logic [23:0] gap;
    logic        gap_ok;
    logic [23:0] gap_exp;

    assign gap_exp = 24'(mult) * (24'(n_val) + 24'h000001);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap    <= 24'h000000;
            gap_ok <= 1'b0;
        end else if (wr_ok && s.awaddr != OFF_IRQ_CLEAR) begin
            gap    <= 24'h000000;
            gap_ok <= 1'b0;
        end else if (s.tick) begin
            gap    <= 24'h000001;
            gap_ok <= 1'b1;
        end else begin
            gap    <= gap + 24'h000001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_ovf_flag_set: assert property (                           // [RQ1]
        abd_ovf_i && s.abd_en && !s.sync_mode |=> ctl_rd[BIT_ABD_OVF])
        else $error("overflow flag not set");
    a_idle_on_start: assert property (                          // [RQ2]
        rx_start_i && !s.sync_mode |=> !ctl_rd[BIT_RX_IDLE])
        else $error("idle flag still set after start bit");
    a_tx_polarity: assert property (                            // [RQ3]
        !s.sync_mode |=> tx_pin_o == ($past(tx_data_i) ^ $past(s.ck_pol)))
        else $error("transmit polarity wrong");
    a_clock_edge: assert property (                             // [RQ4]
        s.sync_mode |=> ck_rising_o == $past(s.ck_pol))
        else $error("sync clock edge select wrong");
    a_tick_period: assert property (                            // [RQ10]
        baud_tick_o && gap_ok |-> gap == gap_exp)
        else $error("bit period does not match divisor and mode");
    a_div_write_clear: assert property (                        // [RQ15]
        div_wr |=> s.timer == 16'h0000 && s.pre == 6'h00 ##1 !baud_tick_o)
        else $error("divisor write did not clear timer");
    a_wake_edge: assert property (                              // [RQ7]
        wake_edge |=> rx_ready_o && !ctl_rd[BIT_WAKE] && irq_o == s.irq_en[IRQ_WAKE] |
                      $past(s.irq))
        else $error("wake edge not handled");
    a_abd_self_clear: assert property (                         // [RQ8]
        s.abd_en && !s.sync_mode && abd_done_i |=> !abd_active_o)
        else $error("auto-baud enable did not clear");
    a_resv_zero: assert property (                              // [RQ9]
        s_axi_rvalid_o && s.r_ctl |-> s_axi_rdata_o[5] == 1'b0 && s_axi_rdata_o[2] == 1'b0)
        else $error("unimplemented control bits read nonzero");
    a_ovf_hold_zero: assert property (                          // [RQ1]
        !s.abd_ovf && !ev[IRQ_ABD_OVF] && !wr_ok |=> !ctl_rd[BIT_ABD_OVF])
        else $error("overflow flag set without overflow");
    a_idle_on_done: assert property (                           // [RQ2]
        rx_done_i && !rx_start_i && !s.sync_mode |=> ctl_rd[BIT_RX_IDLE])
        else $error("idle flag not set after character");
    a_hold_while_armed: assert property (                       // [RQ6]
        s.wake_en && !s.sync_mode && !wake_edge && !wr_ok |=> rx_hold_o)
        else $error("receiver not held while wake armed");
    a_ready_after_clear: assert property (                      // [RQ7]
        rx_ready_o |-> !s.wake_en)
        else $error("wake enable still set after wake edge");
    a_sticky_status: assert property (                          // [RQ1] [RQ6] [RQ8]
        (|ev) |=> (s.irq_stat & $past(ev)) == $past(ev))
        else $error("status event lost");
    a_sync_no_wake: assert property (                           // [RQ6]
        s.sync_mode |=> !rx_ready_o)
        else $error("wake edge taken in sync mode");

    c_tick_seen: cover property (baud_tick_o ##[1:200] baud_tick_o);
    c_wake_seen: cover property (wake_edge ##1 rx_ready_o);
    c_abd_done: cover property (s.abd_en ##1 !s.abd_en);
    c_rx_frame: cover property (rx_start_i ##[1:1000] rx_done_i);
    c_ovf_seen: cover property (ev[IRQ_ABD_OVF] ##1 s.abd_ovf);
endmodule
`default_nettype wire

// ==== testbench/sbg_far_model.sv ====
// Far-side model: receive and transmit shifters and auto-baud events
`timescale 1ns/1ps
`default_nettype none
module sbg_far_model (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       tick_i,
    input  wire logic       hold_i,
    input  wire logic [3:0] req_i,
    output logic            rx_start_o,
    output logic            rx_done_o,
    output logic            rx_line_o,
    output logic            tx_data_o,
    output logic            abd_ovf_o,
    output logic            abd_done_o
);
    logic [3:0] left;
    logic [3:0] lfsr;
    logic [2:0] wake;
    // Start bit low, then shifted bits; a wake request pulls the line low
    assign rx_line_o = (wake == 3'h0) && (left == 4'h0 || (left != 4'hA && lfsr[1]));
    assign tx_data_o = lfsr[0];
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            left       <= 4'h0;
            lfsr       <= 4'h9;
            wake       <= 3'h0;
            rx_start_o <= 1'b0;
            rx_done_o  <= 1'b0;
            abd_ovf_o  <= 1'b0;
            abd_done_o <= 1'b0;
        end else begin
            rx_start_o <= 1'b0;
            rx_done_o  <= 1'b0;
            abd_ovf_o  <= req_i[2];
            abd_done_o <= req_i[3];
            // No character is taken while the receiver is held
            if (req_i[0] && !hold_i && left == 4'h0) begin
                rx_start_o <= 1'b1;
                left       <= 4'hA;
            end else if (tick_i && left != 4'h0) begin
                left      <= left - 4'h1;
                rx_done_o <= (left == 4'h1);
            end
            wake <= req_i[1] ? 3'h7 : wake - 3'(wake != 3'h0);
            if (tick_i) begin
                lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the baud rate generator
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sbg_pkg::*;
    logic clk_i, resetn_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic s_axi_rvalid_o, s_axi_rready_i, rx_start_i, rx_done_i, rx_line_i, tx_data_i;
    logic abd_ovf_i, abd_done_i, baud_tick_o, tx_pin_o, ck_rising_o, rx_ready_o;
    logic rx_hold_o, abd_active_o, irq_o, pin_chk, prev_tx, m_pol, m_sync, hs, wide;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, lo, hi;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i, req;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    int mismatches, tests_run, p, c, k;
    sbg_baud_gen sbg_baud_gen_i (.clk_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
        .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .rx_start_i, .rx_done_i, .rx_line_i, .tx_data_i, .abd_ovf_i, .abd_done_i,
        .baud_tick_o, .tx_pin_o, .ck_rising_o, .rx_ready_o, .rx_hold_o, .abd_active_o, .irq_o);
    sbg_far_model sbg_far_model_i (.clk_i(clk_i), .resetn_i(resetn_i), .tick_i(baud_tick_o),
        .hold_i(rx_hold_o), .req_i(req), .rx_start_o(rx_start_i), .rx_done_o(rx_done_i),
        .rx_line_o(rx_line_i), .tx_data_o(tx_data_i), .abd_ovf_o(abd_ovf_i),
        .abd_done_o(abd_done_i));
    // ****************************************************************
    // Bus, compare and closing tasks
    // ****************************************************************
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= {24'($urandom), d};
        s_axi_wstrb_i   <= 4'($urandom) | 4'h1;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_i);
            if (!aw && s_axi_awready_o) begin
                aw = 1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!w && s_axi_wready_o) begin
                w = 1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        do @(posedge clk_i); while (!s_axi_bvalid_o);
        s_axi_bready_i <= 1'b0;
        check("bresp", 32'(s_axi_bresp_o), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        do @(posedge clk_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (!s_axi_rvalid_o);
        s_axi_rready_i <= 1'b0;
        check("rdata", s_axi_rdata_o, {24'h0, e});
        check("rresp", 32'(s_axi_rresp_o), 32'(er));
    endtask
    task automatic poke(input int i);
        req[i] <= 1'b1;
        @(posedge clk_i);
        req <= 4'h0;
    endtask
    always @(posedge clk_i) begin
        if (pin_chk) begin
            check("tx_pin", 32'(tx_pin_o), 32'(prev_tx ^ (m_pol & !m_sync)));
            check("ck_rising", 32'(ck_rising_o), 32'(m_pol & m_sync));
        end
        prev_tx <= tx_data_i;
    end
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #1_800_000;
        mismatches++;
        end_of_test();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = '0;
        {s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
        {req, pin_chk, m_pol, m_sync} = '0;
        void'($urandom(57114));
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(OFF_BAUD_CONTROL, 8'h40, RESP_OKAY);
        rd(OFF_DIVISOR_HIGH, 8'h00, RESP_OKAY);
        rd(8'h1C, 8'h00, RESP_SLVERR);
        wr(OFF_IRQ_STATUS, 8'h01, RESP_SLVERR);
        for (int i = 0; i < 3; i++) begin
            lo = 8'($urandom);
            wr(OFF_BAUD_CONTROL, lo, RESP_OKAY);
            rd(OFF_BAUD_CONTROL, (lo & 8'h9B) | 8'h40, RESP_OKAY);
        end
        wr(OFF_BAUD_CONTROL, 8'h00, RESP_OKAY);
        rd(OFF_BAUD_CONTROL, 8'h40, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            pin_chk <= 1'b0;
            @(posedge clk_i);
            m_sync = i[2];
            hs = m_sync ? 1'($urandom) : i[1];
            wide = i[0];
            m_pol = 1'($urandom);
            lo = 8'($urandom) & (wide ? 8'hFF : 8'h3F);
            hi = 8'($urandom) & (wide ? 8'h01 : 8'hFF);
            p = (m_sync ? 4 : hs ? (wide ? 4 : 16) : (wide ? 16 : 64));
            p = p * ((wide ? int'({hi, lo}) : int'(lo)) + 1);
            wr(OFF_MODE, {6'h0, hs, m_sync}, RESP_OKAY);
            wr(OFF_BAUD_CONTROL, {3'h0, m_pol, wide, 3'h0}, RESP_OKAY);
            wr(OFF_DIVISOR_HIGH, hi, RESP_OKAY);
            repeat ($urandom % 40) @(posedge clk_i);
            wr(OFF_DIVISOR_LOW, lo, RESP_OKAY);
            pin_chk <= 1'b1;
            c = 0;
            while (!baud_tick_o) begin
                @(posedge clk_i);
                c++;
            end
            check("first_tick", 32'(c + 2 >= p && c <= p), 32'h1);
            c = 0;
            do begin
                @(posedge clk_i);
                c++;
            end while (!baud_tick_o);
            check("period", c, p);
        end
        pin_chk <= 1'b0;
        wr(OFF_MODE, 8'h02, RESP_OKAY);
        wr(OFF_BAUD_CONTROL, 8'h08, RESP_OKAY);
        wr(OFF_DIVISOR_HIGH, 8'h00, RESP_OKAY);
        wr(OFF_DIVISOR_LOW, 8'h09, RESP_OKAY);
        poke(0);
        rd(OFF_BAUD_CONTROL, 8'h08, RESP_OKAY);
        do @(posedge clk_i); while (!rx_done_i);
        rd(OFF_BAUD_CONTROL, 8'h48, RESP_OKAY);
        wr(OFF_IRQ_ENABLE, 8'h07, RESP_OKAY);
        wr(OFF_BAUD_CONTROL, 8'h0A, RESP_OKAY);
        poke(0);
        rd(OFF_BAUD_CONTROL, 8'h4A, RESP_OKAY);
        check("rx_hold", 32'(rx_hold_o), 32'h1);
        poke(1);
        k = 0;
        while (!rx_ready_o && k < 10) begin
            @(posedge clk_i);
            k++;
        end
        check("rx_ready", 32'(rx_ready_o), 32'h1);
        rd(OFF_BAUD_CONTROL, 8'h48, RESP_OKAY);
        check("rx_hold", 32'(rx_hold_o), 32'h0);
        rd(OFF_IRQ_STATUS, 8'h01, RESP_OKAY);
        check("irq", 32'(irq_o), 32'h1);
        wr(OFF_IRQ_ENABLE, 8'h00, RESP_OKAY);
        rd(OFF_IRQ_CLEAR, 8'h00, RESP_OKAY);
        check("irq", 32'(irq_o), 32'h0);
        wr(OFF_IRQ_ENABLE, 8'h07, RESP_OKAY);
        wr(OFF_IRQ_CLEAR, 8'h01, RESP_OKAY);
        rd(OFF_IRQ_STATUS, 8'h00, RESP_OKAY);
        check("irq", 32'(irq_o), 32'h0);
        wr(OFF_BAUD_CONTROL, 8'h09, RESP_OKAY);
        poke(2);
        rd(OFF_BAUD_CONTROL, 8'hC9, RESP_OKAY);
        check("abd_active", 32'(abd_active_o), 32'h1);
        poke(3);
        rd(OFF_BAUD_CONTROL, 8'hC8, RESP_OKAY);
        check("abd_active", 32'(abd_active_o), 32'h0);
        rd(OFF_IRQ_STATUS, 8'h06, RESP_OKAY);
        check("irq", 32'(irq_o), 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
